// ---- rtl/asi_pkg.sv ----
// Shared constants and types for the axis slow-down, home and index input block
package asi_pkg;

  // Clock rate and input filter timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FILTER_TIME_NS = 4000;
  localparam int unsigned FILTER_CYCLES  = FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FILTER_CW      = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_OPERATION_MODE = 8'h00;
  localparam logic [7:0] OFS_ENV_ONE        = 8'h04;
  localparam logic [7:0] OFS_ENV_TWO        = 8'h08;
  localparam logic [7:0] OFS_ENV_THREE      = 8'h0c;
  localparam logic [7:0] OFS_SUB_STATUS     = 8'h10;
  localparam logic [7:0] OFS_EXT_STATUS     = 8'h14;
  localparam logic [7:0] OFS_STOP_CAUSE     = 8'h18;
  localparam logic [7:0] OFS_COMMAND        = 8'h1c;

  // Reset values
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;

  // Operation mode fields and mode codes
  localparam int unsigned OPM_MINUS_DIR_BIT = 3;
  localparam int unsigned OPM_SD_ENABLE_BIT = 8;
  localparam logic [6:0]  MODE_LEAVE_HOME_PLUS   = 7'h12;
  localparam logic [6:0]  MODE_LEAVE_HOME_MINUS  = 7'h1a;
  localparam logic [6:0]  MODE_HOME_SEARCH_PLUS  = 7'h15;
  localparam logic [6:0]  MODE_HOME_SEARCH_MINUS = 7'h1d;
  localparam logic [6:0]  MODE_HOME_RETURN_MINUS = 7'h18;
  localparam logic [6:0]  MODE_INDEX_COUNT_PLUS  = 7'h24;
  localparam logic [6:0]  MODE_INDEX_COUNT_MINUS = 7'h2c;

  // Environment register fields
  localparam int unsigned ENV1_SD_REACTION_BIT = 4;
  localparam int unsigned ENV1_SD_LATCH_BIT    = 5;
  localparam int unsigned ENV1_SD_POL_BIT      = 6;
  localparam int unsigned ENV1_HOME_POL_BIT    = 7;
  localparam int unsigned ENV1_FILTER_BIT      = 26;
  localparam int unsigned ENV2_INDEX_EDGE_BIT  = 16;
  localparam int unsigned ENV3_METHOD_LSB      = 0;
  localparam int unsigned ENV3_INDEX_CNT_LSB   = 4;

  // Status and command fields
  localparam int unsigned SUB_HOME_BIT           = 14;
  localparam int unsigned SUB_SD_LATCH_BIT       = 15;
  localparam int unsigned EXT_INDEX_BIT          = 10;
  localparam int unsigned EXT_PLUS_SD_PIN_BIT    = 15;
  localparam int unsigned EXT_MINUS_SD_PIN_BIT   = 17;
  localparam int unsigned EXT_PLUS_SD_LATCH_BIT  = 22;
  localparam int unsigned EXT_MINUS_SD_LATCH_BIT = 23;
  localparam int unsigned STOP_CAUSE_SD_BIT      = 10;
  localparam int unsigned CMD_START_BIT          = 0;

  // Slow-down reaction states, Gray along idle, slow, stop
  typedef enum logic [1:0]
  {
    SD_IDLE = 2'b00,
    SD_SLOW = 2'b01,
    SD_STOP = 2'b11
  } asi_sd_state_t;

endpackage : asi_pkg

// ---- rtl/asi_input_cond.sv ----
// Sensor input conditioner: two-stage sync, polarity select, pulse filter
`timescale 1ns/100ps
module asi_input_cond #(
  parameter int unsigned FILT = asi_pkg::FILTER_CYCLES,
  parameter int unsigned CW   = asi_pkg::FILTER_CW
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Raw pin and settings
  input  wire logic pin,
  input  wire logic active_high,
  input  wire logic filter_on,
  // Conditioned active level
  output logic      level
);

  logic          sync1;
  logic          sync2;
  logic          cand;
  logic [CW-1:0] cnt;

  // Two flops before any logic looks at the pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // Polarity applied after the synchroniser
  assign cand = active_high ? sync2 : ~sync2;

  // New level accepted only after it outlasts the filter window
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level <= 1'b0;
      cnt   <= '0;
    end
    else if (!filter_on || cand == level)
    begin
      cnt <= '0;
      if (!filter_on)
        level <= cand; // Unfiltered path, level follows the pin three cycles later
    end
    else if (cnt == CW'(FILT))
    begin
      level <= cand;
      cnt   <= '0;
    end
    else
      cnt <= cnt + 1'b1;
  end

  property p_sync_path;
    @(posedge hclk) disable iff (!hresetn)
    $past(hresetn, 3) && !filter_on ##1 !filter_on |-> level == ($past(pin, 3) ~^ $past(active_high));
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("unfiltered level does not follow pin");

  property p_filter_reject;
    @(posedge hclk) disable iff (!hresetn)
    $past(filter_on) && level != $past(level) |-> $past(cnt) == CW'(FILT);
  endproperty
  a_filter_reject: assert property (p_filter_reject) else $error("filtered level changed too early");

endmodule : asi_input_cond

// ---- rtl/asi_index_counter.sv ----
// Encoder index edge counter with selectable edge and target count
`timescale 1ns/100ps
module asi_index_counter #(
  parameter int unsigned CNTW = 4
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // Index level and settings
  input  wire logic            index_level,
  input  wire logic            rising_sel,
  input  wire logic [CNTW-1:0] index_count_minus_one,
  // Control
  input  wire logic            enable,
  input  wire logic            clear,
  // Result
  output logic [CNTW-1:0]      count,
  output logic                 done
);

  logic index_q;
  logic edge_seen;

  // Previous level for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      index_q <= 1'b0;
    else
      index_q <= index_level;
  end

  // Rising when selected, otherwise falling
  assign edge_seen = rising_sel ? (index_level & ~index_q) : (~index_level & index_q);

  // Count edges; done on the edge that finds count equal to the setting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else if (clear)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else if (enable && edge_seen && !done)
    begin
      if (count == index_count_minus_one)
        done <= 1'b1;
      else
        count <= count + 1'b1;
    end
  end

  property p_count_done;
    @(posedge hclk) disable iff (!hresetn)
    !clear && enable && edge_seen && !done && count == index_count_minus_one |=> done;
  endproperty
  a_count_done: assert property (p_count_done) else $error("index target reached but not done");

endmodule : asi_index_counter

// ---- rtl/asi_top.sv ----
// Axis slow-down, home and encoder index input handling with AHB-Lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - Slow-down ignored unless mode bit 8 set
// - Env one bit 6 sets slow-down polarity
// - Env one bit 4: decelerate only or stop
// - Env one bit 5: level or latched slow-down
// - Latch clears on idle start or level mode
// - Sub status shows latch for travel direction
// - Extended status shows slow-down pins and latches
// - Slow-down stop sets stop cause bit 10
// - Filter bit 26 rejects slow-down pulses <=4us
// - Home and index act only in homing and index modes
// - Home latched until the axis stops
// - Decode listed homing and index mode codes
// - Env three bits 0-3 pick homing method
// - Env one bit 7 sets home polarity
// - Sub status bit 14 shows home input
// - Env three bits 4-7 hold index count-1
// - Env two edge select: falling or rising
// - Extended status bit 10 shows index input
// - Filter bit 26 also filters index input
// - Decelerate-only ignored during constant speed feed
// - Slow-down stop drives active-low interrupt
module asi_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sensor pins
  input  wire logic        plus_slowdown_pin,
  input  wire logic        minus_slowdown_pin,
  input  wire logic        home_sensor_input,
  input  wire logic        encoder_index_input,
  // Motion core status
  input  wire logic        axis_running,
  input  wire logic        high_speed_phase,
  // Motion core requests
  output logic             start_cmd,
  output logic             move_minus,
  output logic             slowdown_decel,
  output logic             slowdown_stop,
  output logic             home_latched,
  output logic             index_count_done,
  output logic [3:0]       homing_method,
  // Interrupt
  output logic             int_n
);

  logic [31:0] operation_mode;
  logic [31:0] environment_config_one;
  logic [31:0] environment_config_two;
  logic [31:0] environment_config_three;
  logic        stop_cause_sd;
  logic        next_stop_cause_sd;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ok;
  logic        start_wr;
  logic        cause_clr;
  logic [31:0] rd_value;
  logic [15:0] sub_status_word;
  logic [31:0] extended_status;
  logic [1:0]  sd_level;
  logic [1:0]  slowdown_latch;
  logic [1:0]  sd_eff;
  logic        sd_dir;
  logic        sd_enable;
  logic        sd_stop_sel;
  logic        sd_latch_sel;
  logic        filter_on;
  logic        home_level;
  logic        index_level;
  logic        home_mode;
  logic        index_mode;
  logic [3:0]  index_count;
  asi_pkg::asi_sd_state_t sd_state;
  asi_pkg::asi_sd_state_t next_sd_state;
  logic                   sd_cur;
  logic                   motion_mode;
  logic                   bus_req;
  logic [1:0]             sd_pins;

  // The bus side never stalls: reads are answered from registered status,
  // writes land one cycle after their address phase. Status read in the
  // cycle right after a settings write still shows the old settings.

  // Only a selected, real transfer opens an address phase
  assign bus_req = hsel && htrans[1] && hready;
  // Upper address bits must be clear; aliases would hide wiring faults
  assign addr_ok = (haddr[31:8] == 24'h00_0000);

  // No wait states and no error responses: every access is one data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address kept for the data phase, when the write data arrive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_req && hwrite && addr_ok;
      wr_addr <= haddr[7:0];
    end
  end

  // Start strobe, also the clear for the stop cause
  assign start_wr  = wr_pend && (wr_addr == asi_pkg::OFS_COMMAND) && hwdata[asi_pkg::CMD_START_BIT];
  assign cause_clr = start_wr;

  // Write-only setting registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      operation_mode           <= asi_pkg::RST_CONFIG;
      environment_config_one   <= asi_pkg::RST_CONFIG;
      environment_config_two   <= asi_pkg::RST_CONFIG;
      environment_config_three <= asi_pkg::RST_CONFIG;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        asi_pkg::OFS_OPERATION_MODE: operation_mode           <= hwdata;
        asi_pkg::OFS_ENV_ONE:        environment_config_one   <= hwdata;
        asi_pkg::OFS_ENV_TWO:        environment_config_two   <= hwdata;
        asi_pkg::OFS_ENV_THREE:      environment_config_three <= hwdata;
        default:                     operation_mode           <= operation_mode;
      endcase
    end
  end

  // Readable words; write-only settings read back as zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (haddr[7:0])
      asi_pkg::OFS_SUB_STATUS: rd_value = {16'h0000, sub_status_word};
      asi_pkg::OFS_EXT_STATUS: rd_value = extended_status;
      asi_pkg::OFS_STOP_CAUSE: rd_value[asi_pkg::STOP_CAUSE_SD_BIT] = stop_cause_sd;
      default:                 rd_value = 32'h0000_0000;
    endcase
  end

  // Read data taken in the address phase so it stands for the whole data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (bus_req && !hwrite && addr_ok)
      hrdata <= rd_value;
  end

  // Setting fields used by the input logic or passed to the motion core
  assign sd_enable     = operation_mode[asi_pkg::OPM_SD_ENABLE_BIT];
  assign sd_stop_sel   = environment_config_one[asi_pkg::ENV1_SD_REACTION_BIT];
  assign sd_latch_sel  = environment_config_one[asi_pkg::ENV1_SD_LATCH_BIT];
  assign filter_on     = environment_config_one[asi_pkg::ENV1_FILTER_BIT];
  assign sd_dir        = operation_mode[asi_pkg::OPM_MINUS_DIR_BIT];
  assign move_minus    = operation_mode[asi_pkg::OPM_MINUS_DIR_BIT];
  assign homing_method = environment_config_three[asi_pkg::ENV3_METHOD_LSB +: 4];

  // Homing and index-count mode codes; every other code keeps both inputs idle
  always_comb
  begin
    home_mode  = 1'b0;
    index_mode = 1'b0;
    case (operation_mode[6:0])
      asi_pkg::MODE_LEAVE_HOME_PLUS,
      asi_pkg::MODE_LEAVE_HOME_MINUS,
      asi_pkg::MODE_HOME_SEARCH_PLUS,
      asi_pkg::MODE_HOME_SEARCH_MINUS,
      asi_pkg::MODE_HOME_RETURN_MINUS: home_mode  = 1'b1;
      asi_pkg::MODE_INDEX_COUNT_PLUS,
      asi_pkg::MODE_INDEX_COUNT_MINUS: index_mode = 1'b1;
      default:                         home_mode  = 1'b0;
    endcase
  end

  // Home and index act only in these modes
  assign motion_mode = home_mode || index_mode;

  // Plus side is channel 0, minus side channel 1
  assign sd_pins = {minus_slowdown_pin, plus_slowdown_pin};

  // One conditioner and one latch per slow-down side
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_sd_chan
    asi_input_cond #(
      .FILT (asi_pkg::FILTER_CYCLES),
      .CW   (asi_pkg::FILTER_CW)
    ) u_cond (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .pin         (sd_pins[ch]),
      .active_high (environment_config_one[asi_pkg::ENV1_SD_POL_BIT]),
      .filter_on   (filter_on),
      .level       (sd_level[ch])
    );

    // Set beats a start strobe; a start only clears an inactive input
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        slowdown_latch[ch] <= 1'b0;
      else if (!sd_latch_sel)
        slowdown_latch[ch] <= 1'b0;
      else if (sd_enable && sd_level[ch])
        slowdown_latch[ch] <= 1'b1;
      else if (start_wr && !sd_level[ch])
        slowdown_latch[ch] <= 1'b0;
    end

    // Latched or plain level, both gated by the enable
    assign sd_eff[ch] = sd_enable && (sd_latch_sel ? slowdown_latch[ch] : sd_level[ch]);
  end

  // Home switch, polarity from its own setting bit
  asi_input_cond #(
    .FILT (asi_pkg::FILTER_CYCLES),
    .CW   (asi_pkg::FILTER_CW)
  ) u_home_cond (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (home_sensor_input),
    .active_high (environment_config_one[asi_pkg::ENV1_HOME_POL_BIT]),
    .filter_on   (filter_on),
    .level       (home_level)
  );

  // Index channel: the edge choice, not a polarity, decides what counts
  asi_input_cond #(
    .FILT (asi_pkg::FILTER_CYCLES),
    .CW   (asi_pkg::FILTER_CW)
  ) u_index_cond (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin         (encoder_index_input),
    .active_high (1'b1),
    .filter_on   (filter_on),
    .level       (index_level)
  );

  // Home activation held so a short sensor pulse is not lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      home_latched <= 1'b0;
    else if (!axis_running)
      home_latched <= 1'b0;
    else if (motion_mode && home_level)
      home_latched <= 1'b1;
  end

  // Index edges counted while moving in a home or index mode
  asi_index_counter #(
    .CNTW (4)
  ) u_index_cnt (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .index_level           (index_level),
    .rising_sel            (environment_config_two[asi_pkg::ENV2_INDEX_EDGE_BIT]),
    .index_count_minus_one (environment_config_three[asi_pkg::ENV3_INDEX_CNT_LSB +: 4]),
    .enable                (motion_mode && axis_running),
    .clear                 (start_wr),
    .count                 (index_count),
    .done                  (index_count_done)
  );

  // Status words assembled from conditioned levels and latches
  always_comb
  begin
    sub_status_word = 16'h0000;
    sub_status_word[asi_pkg::SUB_HOME_BIT]     = home_level;
    sub_status_word[asi_pkg::SUB_SD_LATCH_BIT] = slowdown_latch[sd_dir];
    extended_status = 32'h0000_0000;
    extended_status[asi_pkg::EXT_INDEX_BIT]          = index_level;
    extended_status[asi_pkg::EXT_PLUS_SD_PIN_BIT]    = sd_level[0];
    extended_status[asi_pkg::EXT_MINUS_SD_PIN_BIT]   = sd_level[1];
    extended_status[asi_pkg::EXT_PLUS_SD_LATCH_BIT]  = slowdown_latch[0];
    extended_status[asi_pkg::EXT_MINUS_SD_LATCH_BIT] = slowdown_latch[1];
  end

  // Only the side we are travelling toward can slow the axis
  assign sd_cur = sd_eff[sd_dir];

  // Reaction to the active slow-down of the travel direction
  always_comb
  begin
    next_sd_state = sd_state;
    case (sd_state)
      asi_pkg::SD_IDLE:
      begin
        if (axis_running && sd_cur && sd_stop_sel)
          next_sd_state = asi_pkg::SD_STOP;
        else if (axis_running && sd_cur && high_speed_phase)
          next_sd_state = asi_pkg::SD_SLOW;
      end
      asi_pkg::SD_SLOW:
      begin
        if (!axis_running || !sd_cur)
          next_sd_state = asi_pkg::SD_IDLE;
        else if (sd_stop_sel)
          next_sd_state = asi_pkg::SD_STOP;
      end
      asi_pkg::SD_STOP:
      begin
        // A level input that drops before rest lets the axis speed up again
        if (!axis_running || !sd_cur)
          next_sd_state = asi_pkg::SD_IDLE;
      end
      default:
        next_sd_state = asi_pkg::SD_IDLE;
    endcase
  end

  // State and the motion core requests, all registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sd_state       <= asi_pkg::SD_IDLE;
      slowdown_decel <= 1'b0;
      slowdown_stop  <= 1'b0;
      start_cmd      <= 1'b0;
    end
    else
    begin
      sd_state       <= next_sd_state;
      slowdown_decel <= (next_sd_state != asi_pkg::SD_IDLE);
      slowdown_stop  <= (next_sd_state == asi_pkg::SD_STOP);
      start_cmd      <= start_wr;
    end
  end

  // Stop cause set at rest after a slow-down stop; the set beats a start clear
  always_comb
  begin
    if (sd_state == asi_pkg::SD_STOP && !axis_running)
      next_stop_cause_sd = 1'b1;
    else if (cause_clr)
      next_stop_cause_sd = 1'b0;
    else
      next_stop_cause_sd = stop_cause_sd;
  end

  // Interrupt follows the cause, so it stays low until the next start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stop_cause_sd <= 1'b0;
      int_n         <= 1'b1;
    end
    else
    begin
      stop_cause_sd <= next_stop_cause_sd;
      int_n         <= ~next_stop_cause_sd;
    end
  end

  // Axis brought to rest by a slow-down stop
  sequence s_sd_at_rest;
    sd_state == asi_pkg::SD_STOP && !axis_running;
  endsequence

  property p_sd_disabled;
    @(posedge hclk) disable iff (!hresetn)
    sd_state == asi_pkg::SD_IDLE && !sd_enable |=> sd_state == asi_pkg::SD_IDLE;
  endproperty
  a_sd_disabled: assert property (p_sd_disabled) else $error("slow-down acted while disabled");

  property p_level_clears_latch;
    @(posedge hclk) disable iff (!hresetn)
    !sd_latch_sel |=> slowdown_latch == 2'b00;
  endproperty
  a_level_clears_latch: assert property (p_level_clears_latch) else $error("latch kept in level mode");

  property p_stop_cause;
    @(posedge hclk) disable iff (!hresetn)
    s_sd_at_rest |=> stop_cause_sd && !int_n;
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("slow-down stop without cause");

  property p_home_clear;
    @(posedge hclk) disable iff (!hresetn)
    !axis_running |=> !home_latched;
  endproperty
  a_home_clear: assert property (p_home_clear) else $error("home latch held at rest");

  property p_const_speed_ignored;
    @(posedge hclk) disable iff (!hresetn)
    sd_state == asi_pkg::SD_IDLE && !high_speed_phase && !sd_stop_sel |=> sd_state == asi_pkg::SD_IDLE;
  endproperty
  a_const_speed_ignored: assert property (p_const_speed_ignored) else $error("slowed at constant speed");

endmodule : asi_top

// ---- tb/asi_sensor_model.sv ----
// Behavioural model of the axis sensors, home switch and encoder index
`timescale 1ns/100ps
module asi_sensor_model (
  // Sensor pins toward the device
  output logic plus_pin,
  output logic minus_pin,
  output logic home_pin,
  output logic index_pin
);
  // Pins start low, the active level for slow-down and home at reset polarity
  initial {plus_pin, minus_pin, home_pin, index_pin} = 4'h0;
  // Callers hold every level for at least the minimum pulse width
  task automatic set_pins(input logic [3:0] lv);
    {plus_pin, minus_pin, home_pin, index_pin} <= lv;
  endtask : set_pins
endmodule : asi_sensor_model

// ---- tb/tb_top.sv ----
// Register-level testbench for the slow-down, home and index input block
`timescale 1ns/100ps
module tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        axis_running = 1'b0, high_speed_phase = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, pp, mp, hp, ip;
  logic        hresp, start_cmd, move_minus, sd_decel, sd_stop, home_latched, index_done, int_n;
  logic [3:0]  homing_method;
  int          starts_seen = 0;
  int          err_total = 0, checked = 0;
  // Free-running 100 MHz clock
  always #5 hclk = ~hclk;
  asi_sensor_model m (.plus_pin(pp), .minus_pin(mp), .home_pin(hp), .index_pin(ip));
  asi_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .plus_slowdown_pin(pp), .minus_slowdown_pin(mp),
    .home_sensor_input(hp), .encoder_index_input(ip), .axis_running(axis_running),
    .high_speed_phase(high_speed_phase), .start_cmd(start_cmd), .move_minus(move_minus),
    .slowdown_decel(sd_decel), .slowdown_stop(sd_stop), .home_latched(home_latched),
    .index_count_done(index_done), .homing_method(homing_method), .int_n(int_n));
  // Start strobe lasts one cycle, so count it as it passes
  always @(posedge hclk)
    if (start_cmd === 1'b1)
      starts_seen <= starts_seen + 1;
  // Single AHB transfer; waits on the slave however long it takes
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic chk(input string n, input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", n, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Watchdog well beyond the roughly 1250 cycles the tests need
  initial
  begin
    #200us;
    err_total++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 8'h08, 32'h0001_0000);
    // Every polarity against every pin level, filter off
    for (int p = 0; p < 2; p++)
      for (int v = 0; v < 2; v++)
      begin
        ahb(1'b1, 8'h04, p ? 32'h0000_00c0 : 32'h0);
        m.set_pins({4{v[0]}});
        repeat (8) @(posedge hclk);
        ahb(1'b0, 8'h14, 32'h0);
        chk("plus pin", rd[15], v[0] == p[0]);
        chk("minus pin", rd[17], v[0] == p[0]);
        chk("index", rd[10], v[0]);
        ahb(1'b0, 8'h10, 32'h0);
        chk("home", rd[14], v[0] == p[0]);
      end
    $display("polarity test done");
    // A new level is still rejected after 40 cycles and passes the filter after 540
    ahb(1'b1, 8'h04, 32'h0400_00c0);
    m.set_pins(4'h0);
    repeat (500) @(posedge hclk);
    m.set_pins(4'h9);
    repeat (40) @(posedge hclk);
    ahb(1'b0, 8'h14, 32'h0);
    chk("short plus", rd[15], 1'b0);
    chk("short index", rd[10], 1'b0);
    repeat (500) @(posedge hclk);
    ahb(1'b0, 8'h14, 32'h0);
    chk("long plus", rd[15], 1'b1);
    chk("long index", rd[10], 1'b1);
    $display("filter test done");
    // Latched slow-down survives release, clears on level mode
    ahb(1'b1, 8'h00, 32'h0000_0100);
    axis_running <= 1'b1;
    ahb(1'b1, 8'h04, 32'h0000_00e0);
    m.set_pins(4'h0);
    repeat (10) @(posedge hclk);
    m.set_pins(4'h8);
    repeat (10) @(posedge hclk);
    m.set_pins(4'h0);
    repeat (10) @(posedge hclk);
    ahb(1'b0, 8'h14, 32'h0);
    chk("plus latch", rd[22], 1'b1);
    ahb(1'b1, 8'h04, 32'h0000_00c0);
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h14, 32'h0);
    chk("latch cleared", rd[22], 1'b0);
    $display("latch test done");
    // Decelerate only at high speed; a stop sets cause and interrupt
    m.set_pins(4'h8);
    repeat (10) @(posedge hclk);
    chk("decel at constant speed", sd_decel, 1'b0);
    high_speed_phase <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("decel at high speed", sd_decel, 1'b1);
    chk("no stop request", sd_stop, 1'b0);
    m.set_pins(4'h0);
    high_speed_phase <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("decel released", sd_decel, 1'b0);
    ahb(1'b1, 8'h04, 32'h0000_00d0);
    m.set_pins(4'h8);
    repeat (10) @(posedge hclk);
    chk("stop request", sd_stop, 1'b1);
    axis_running <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("interrupt", int_n, 1'b0);
    ahb(1'b0, 8'h18, 32'h0);
    chk("stop cause", rd[10], 1'b1);
    chk("bus response", hresp, 1'b0);
    $display("reaction test done");
    // Home latch and index count during a home search
    m.set_pins(4'h0);
    ahb(1'b1, 8'h00, 32'h0000_0015);
    ahb(1'b1, 8'h0c, 32'h0000_0013);
    ahb(1'b1, 8'h1c, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk("start strobe", starts_seen == 1, 1'b1);
    chk("interrupt cleared", int_n, 1'b1);
    axis_running <= 1'b1;
    m.set_pins(4'h2);
    repeat (5) @(posedge hclk);
    m.set_pins(4'h0);
    repeat (5) @(posedge hclk);
    chk("home latched", home_latched, 1'b1);
    chk("home direction", move_minus, 1'b0);
    chk("method", homing_method == 4'h3, 1'b1);
    repeat (2)
    begin
      m.set_pins(4'h1);
      repeat (5) @(posedge hclk);
      m.set_pins(4'h0);
      repeat (5) @(posedge hclk);
    end
    chk("index target", index_done, 1'b1);
    axis_running <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("home released", home_latched, 1'b0);
    $display("home test done");
    end_of_test();
  end
endmodule : tb_top
